// ---- rcs_cfg.svh ----
// constants of the reader command sequencer
`ifndef RCS_CFG_SVH
`define RCS_CFG_SVH
`define RCS_C_IDLE 5'h00
`define RCS_C_LOW_POWER_CARD_DETECT 5'h01
`define RCS_C_LKEY 5'h02
`define RCS_C_AUTH 5'h03
`define RCS_C_TAG 5'h04
`define RCS_C_RX 5'h05
`define RCS_C_TX 5'h06
`define RCS_C_TRX 5'h07
`define RCS_C_NWR 5'h08
`define RCS_C_NPG 5'h09
`define RCS_C_NRD 5'h0A
`define RCS_C_LREG 5'h0C
`define RCS_C_PROT 5'h0D
`define RCS_C_KFET 5'h0E
`define RCS_C_KST 5'h0F
`define RCS_C_RNG 5'h1C
`define RCS_C_RST 5'h1F
`define RCS_A_CMD 5'h00
`define RCS_A_STAT 5'h04
`define RCS_A_EVT 5'h08
`define RCS_A_LIM 5'h0C
`define RCS_LIM_RST 32'hFF00_FF00
`define RCS_STBY_BIT 7
`define RCS_E_IDLE 0
`define RCS_E_CARD 1
`define RCS_E_PROT 2
`define RCS_E_WERR 3
`define RCS_E_RX 4
`define RCS_E_TX 5
`define RCS_E_TMR 6
`define RCS_E_ABRT 7
`define RCS_KEY_LEN 4'h6
`define RCS_PAGE_LEN 9'h040
`define RCS_PAGE_MAX 8'h7F
`define RCS_SEC_LSB 10
`define RCS_SECTOR 3'h2
`define RCS_KEY_BASE 13'h0C00
`define RCS_PROT_BASE 13'h0E00
`define RCS_PROT_LEN 9'h008
`define RCS_RX_REG 8'h20
`define RCS_TX_REG 8'h28
`define RCS_OKAY 2'h0
`define RCS_SLVERR 2'h2
`endif

// ---- rcs_pkg.sv ----
// types of the reader command sequencer
package rcs_pkg;
	typedef enum logic [4:0] {
		ST_IDLE  = 5'h01,
		ST_WAIT  = 5'h02,
		ST_FETCH = 5'h04,
		ST_RUN   = 5'h08,
		ST_DONE  = 5'h10
	} rcs_state_t;
	typedef struct packed {
		logic        req;
		logic        we;
		logic [12:0] addr;
		logic [7:0]  wdata;
	} rcs_nvm_t;
endpackage

// ---- rcs_top.sv ----
// command decoder and sequencer with AXI4-Lite registers
//
// Implementation choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "rcs_cfg.svh"
//Behaviour
// - code 00h idles the sequencer and aborts the running command
// - code 01h runs a low-power card detection cycle
// - after wake, compare I and Q samples with limits, flag card detect
// - card detection ends in standby only when standby is selected
// - 02h moves six key bytes to key buffer, aborts if fewer present
// - during authentication queue access blocked, write error flagged, rx/tx events suppressed
// - authentication ends by itself on success and sets cipher active
// - authentication error sets protocol error and clears cipher active
// - 04h runs the tag query, acknowledge, new-handle exchange
// - 05h enables the receive path
// - 06h transmits the queue bytes
// - 07h transmits then switches the receiver on
// - 08h takes address high, low, data and writes one memory byte
// - 09h takes page address and 1 to 64 bytes, writes the page
// - 0Ah takes address and length, copies memory bytes to the queue
// - 0Ch copies memory bytes to registers; source must be sector 2
// - 0Dh loads receive and transmit protocol presets from memory
// - 0Eh fetches stored key by index; 0Fh stores index plus six bytes
// - 1Ch pushes random bytes to the queue until full
// - commands other than 02h and 09h wait until all argument bytes are queued
// - writing a new code aborts the running command and starts it
module rcs_top #(
	parameter int ADDR_W = 5
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [ADDR_W-1:0] awaddr,
	input  wire logic              awvalid,
	output logic                   awready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output logic                   wready,
	output logic [1:0]             bresp,
	output logic                   bvalid,
	input  wire logic              bready,
	input  wire logic [ADDR_W-1:0] araddr,
	input  wire logic              arvalid,
	output logic                   arready,
	output logic [31:0]            rdata,
	output logic [1:0]             rresp,
	output logic                   rvalid,
	input  wire logic              rready,
	input  wire logic [7:0]        q_level,
	input  wire logic [7:0]        q_rdata,
	input  wire logic              q_full,
	input  wire logic              q_host_access,
	output logic                   q_pop,
	output logic                   q_push,
	output logic [7:0]             q_wdata,
	output logic                   q_block,
	output logic [7:0]             out_byte,
	output logic                   key_wr,
	output logic                   auth_wr,
	output logic                   auth_start,
	input  wire logic              auth_ok,
	input  wire logic              auth_err,
	output logic                   tag_start,
	input  wire logic              tag_done,
	output logic                   tx_start,
	input  wire logic              tx_done,
	output logic                   rx_on,
	input  wire logic              rx_done,
	input  wire logic              timer_event,
	input  wire logic              low_power_card_detect_valid,
	input  wire logic [7:0]        low_power_card_detect_i,
	input  wire logic [7:0]        low_power_card_detect_q,
	output logic                   standby_req,
	output rcs_pkg::rcs_nvm_t      nvm,
	input  wire logic              nvm_ack,
	input  wire logic [7:0]        nvm_rdata,
	output logic                   reg_wr,
	output logic [7:0]             reg_idx,
	input  wire logic [7:0]        rng_byte,
	output logic                   soft_reset
);
	if (ADDR_W < 5)
	begin : g_chk
		$error("ADDR_W too small for the register map");
	end

	// ----------------------------------------
	// decode helpers
	// ----------------------------------------
	function automatic logic [3:0] need_args(input logic [4:0] c);
		case (c)
			`RCS_C_LKEY, `RCS_C_AUTH: need_args = `RCS_KEY_LEN;
			`RCS_C_NWR, `RCS_C_NRD:   need_args = 4'h3;
			`RCS_C_NPG, `RCS_C_KFET:  need_args = 4'h1;
			`RCS_C_LREG:              need_args = 4'h4;
			`RCS_C_PROT:              need_args = 4'h2;
			`RCS_C_KST:               need_args = 4'h7;
			default:                  need_args = 4'h0;
		endcase
	endfunction

	function automatic logic [12:0] slot_addr(input logic [7:0] n);
		slot_addr = 13'(`RCS_KEY_BASE + 13'(n) * 13'(`RCS_KEY_LEN));
	endfunction

	function automatic logic [4:0] word_of(input logic [ADDR_W-1:0] a);
		word_of = {a[4:2], 2'b00};
	endfunction

	rcs_pkg::rcs_state_t st_reg;
	logic [4:0]  cmd_reg;
	logic        stby_sel_reg;
	logic [31:0] lim_reg;
	logic [7:0]  ev_reg;
	logic [7:0]  ev_set;
	logic        ciph_reg;
	logic        aw_hold_reg;
	logic        w_hold_reg;
	logic [ADDR_W-1:0] aw_addr_reg;
	logic [31:0] w_data_reg;
	logic [3:0]  w_strb_reg;
	logic        wr_go;
	logic        cmd_wr;
	logic        evt_wr;
	logic [7:0]  arg_reg [0:7];
	logic [3:0]  idx_reg;
	logic [8:0]  cnt_reg;
	logic        ph_reg;
	logic        low_power_card_detect_hit;
	logic        in_auth;
	logic        rst;

	assign rst = !aresetn || soft_reset;
	assign in_auth = st_reg == rcs_pkg::ST_RUN && cmd_reg == `RCS_C_AUTH;
	assign low_power_card_detect_hit = low_power_card_detect_i < lim_reg[7:0] || low_power_card_detect_i > lim_reg[15:8]
		|| low_power_card_detect_q < lim_reg[23:16] || low_power_card_detect_q > lim_reg[31:24];

	// ----------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------
	assign wr_go = aw_hold_reg && w_hold_reg && !bvalid;
	assign cmd_wr = wr_go && word_of(aw_addr_reg) == `RCS_A_CMD && w_strb_reg[0];
	assign evt_wr = wr_go && word_of(aw_addr_reg) == `RCS_A_EVT && w_strb_reg[0];

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_hold_reg <= 1'b0;
			w_hold_reg  <= 1'b0;
			awready     <= 1'b0;
			wready      <= 1'b0;
			bvalid      <= 1'b0;
			bresp       <= `RCS_OKAY;
			aw_addr_reg <= '0;
			w_data_reg  <= 32'h0000_0000;
			w_strb_reg  <= 4'h0;
		end
		else
		begin
			awready <= !aw_hold_reg && !(awvalid && awready);
			wready  <= !w_hold_reg && !(wvalid && wready);
			if (awvalid && awready)
			begin
				aw_hold_reg <= 1'b1;
				aw_addr_reg <= awaddr;
			end
			if (wvalid && wready)
			begin
				w_hold_reg <= 1'b1;
				w_data_reg <= wdata;
				w_strb_reg <= wstrb;
			end
			if (wr_go)
			begin
				aw_hold_reg <= 1'b0;
				w_hold_reg  <= 1'b0;
				bvalid      <= 1'b1;
				bresp       <= aw_addr_reg > ADDR_W'(`RCS_A_LIM) ? `RCS_SLVERR : `RCS_OKAY;
			end
			else if (bready)
				bvalid <= 1'b0;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			arready <= 1'b0;
			rvalid  <= 1'b0;
			rdata   <= 32'h0000_0000;
			rresp   <= `RCS_OKAY;
		end
		else
		begin
			arready <= !rvalid && !(arvalid && arready);
			if (arvalid && arready)
			begin
				rvalid <= 1'b1;
				rresp  <= `RCS_OKAY;
				case (word_of(araddr))
					`RCS_A_CMD:  rdata <= {24'h0, stby_sel_reg, 2'h0, cmd_reg};
					`RCS_A_STAT: rdata <= {28'h0, standby_req, q_block, ciph_reg,
						st_reg != rcs_pkg::ST_IDLE};
					`RCS_A_EVT:  rdata <= {24'h0, ev_reg};
					`RCS_A_LIM:  rdata <= lim_reg;
					default:
					begin
						rdata <= 32'h0000_0000;
						rresp <= `RCS_SLVERR;
					end
				endcase
				if (araddr > ADDR_W'(`RCS_A_LIM))
					rresp <= `RCS_SLVERR;
			end
			else if (rready)
				rvalid <= 1'b0;
		end
	end

	// ----------------------------------------
	// configuration
	// ----------------------------------------
	always_ff @(posedge aclk)
	begin
		if (rst)
		begin
			stby_sel_reg <= 1'b0;
			lim_reg      <= `RCS_LIM_RST;
		end
		else
		begin
			if (cmd_wr)
				stby_sel_reg <= w_data_reg[`RCS_STBY_BIT];
			if (wr_go && word_of(aw_addr_reg) == `RCS_A_LIM)
			begin
				for (int b = 0; b < 4; b++)
					if (w_strb_reg[b])
						lim_reg[b*8 +: 8] <= w_data_reg[b*8 +: 8];
			end
		end
	end

	// ----------------------------------------
	// event flags, set beats clear
	// ----------------------------------------
	always_comb
	begin
		ev_set = 8'h00;
		ev_set[`RCS_E_IDLE] = st_reg == rcs_pkg::ST_DONE
			|| (cmd_wr && st_reg != rcs_pkg::ST_IDLE);
		ev_set[`RCS_E_CARD] = st_reg == rcs_pkg::ST_RUN && cmd_reg == `RCS_C_LOW_POWER_CARD_DETECT
			&& low_power_card_detect_valid && low_power_card_detect_hit;
		ev_set[`RCS_E_PROT] = in_auth && auth_err;
		ev_set[`RCS_E_WERR] = in_auth && q_host_access;
		ev_set[`RCS_E_RX] = rx_done && !in_auth;
		ev_set[`RCS_E_TX] = tx_done && !in_auth;
		ev_set[`RCS_E_TMR] = timer_event;
		ev_set[`RCS_E_ABRT] = st_reg == rcs_pkg::ST_WAIT && ((cmd_reg == `RCS_C_LKEY
			&& q_level < 8'(`RCS_KEY_LEN)) || (cmd_reg == `RCS_C_NPG && q_level < 8'h02));
	end

	always_ff @(posedge aclk)
	begin
		if (rst)
			ev_reg <= 8'h00;
		else
			ev_reg <= (ev_reg & ~(evt_wr ? w_data_reg[7:0] : 8'h00)) | ev_set;
	end

	always_ff @(posedge aclk)
	begin
		if (rst)
			ciph_reg <= 1'b0;
		else if (in_auth && auth_err)
			ciph_reg <= 1'b0;
		else if (in_auth && auth_ok)
			ciph_reg <= 1'b1;
	end

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	always_ff @(posedge aclk)
	begin
		if (rst)
		begin
			st_reg      <= rcs_pkg::ST_IDLE;
			cmd_reg     <= `RCS_C_IDLE;
			idx_reg     <= 4'h0;
			cnt_reg     <= 9'h000;
			ph_reg      <= 1'b0;
			q_pop       <= 1'b0;
			q_push      <= 1'b0;
			q_wdata     <= 8'h00;
			q_block     <= 1'b0;
			out_byte    <= 8'h00;
			key_wr      <= 1'b0;
			auth_wr     <= 1'b0;
			auth_start  <= 1'b0;
			tag_start   <= 1'b0;
			tx_start    <= 1'b0;
			rx_on       <= 1'b0;
			standby_req <= 1'b0;
			nvm         <= '0;
			reg_wr      <= 1'b0;
			reg_idx     <= 8'h00;
			soft_reset  <= 1'b0;
			for (int i = 0; i < 8; i++)
				arg_reg[i] <= 8'h00;
		end
		else
		begin
			q_pop      <= 1'b0;
			q_push     <= 1'b0;
			key_wr     <= 1'b0;
			auth_wr    <= 1'b0;
			auth_start <= 1'b0;
			tag_start  <= 1'b0;
			tx_start   <= 1'b0;
			reg_wr     <= 1'b0;
			if (cmd_wr)
			begin
				// new code aborts whatever runs
				cmd_reg     <= w_data_reg[4:0];
				idx_reg     <= 4'h0;
				ph_reg      <= 1'b0;
				q_block     <= 1'b0;
				rx_on       <= 1'b0;
				nvm.req     <= 1'b0;
				standby_req <= 1'b0;
				st_reg      <= w_data_reg[4:0] == `RCS_C_IDLE ? rcs_pkg::ST_DONE
					: rcs_pkg::ST_WAIT;
			end
			else
			begin
				unique case (st_reg)
					rcs_pkg::ST_IDLE:
					begin
					end
					rcs_pkg::ST_WAIT:
					begin
						if ((cmd_reg == `RCS_C_LKEY && q_level < 8'(`RCS_KEY_LEN))
							|| (cmd_reg == `RCS_C_NPG && q_level < 8'h02))
							st_reg <= rcs_pkg::ST_DONE;
						else if (q_level >= 8'(need_args(cmd_reg)))
							st_reg <= rcs_pkg::ST_FETCH;
					end
					rcs_pkg::ST_FETCH:
					begin
						// arguments kept in arrival order
						if (idx_reg < need_args(cmd_reg))
						begin
							if (!q_pop)
							begin
								q_pop <= 1'b1;
								arg_reg[idx_reg[2:0]] <= q_rdata;
								idx_reg <= idx_reg + 4'h1;
							end
						end
						else
						begin
							st_reg  <= rcs_pkg::ST_RUN;
							idx_reg <= 4'h0;
							q_block <= cmd_reg == `RCS_C_AUTH;
							cnt_reg <= 9'h001;
							reg_idx <= arg_reg[2];
							case (cmd_reg)
								`RCS_C_NWR, `RCS_C_NRD, `RCS_C_LREG:
									nvm.addr <= {arg_reg[0][4:0], arg_reg[1]};
								`RCS_C_NPG:
									nvm.addr <= 13'(arg_reg[0]) * 13'(`RCS_PAGE_LEN);
								`RCS_C_KFET, `RCS_C_KST:
									nvm.addr <= slot_addr(arg_reg[0]);
								`RCS_C_PROT:
									nvm.addr <= 13'(`RCS_PROT_BASE
										+ 13'(arg_reg[0]) * 13'(`RCS_PROT_LEN));
								default:
									nvm.addr <= 13'h0000;
							endcase
							case (cmd_reg)
								`RCS_C_NPG:  cnt_reg <= `RCS_PAGE_LEN;
								`RCS_C_NRD:  cnt_reg <= {1'b0, arg_reg[2]};
								`RCS_C_LREG: cnt_reg <= {1'b0, arg_reg[3]};
								`RCS_C_PROT: cnt_reg <= `RCS_PROT_LEN;
								`RCS_C_KFET, `RCS_C_KST: cnt_reg <= 9'(`RCS_KEY_LEN);
								default:     cnt_reg <= 9'h001;
							endcase
							if (cmd_reg == `RCS_C_PROT)
								reg_idx <= `RCS_RX_REG;
							if ((cmd_reg == `RCS_C_NPG && arg_reg[0] > `RCS_PAGE_MAX)
								|| (cmd_reg == `RCS_C_LREG && arg_reg[0][(`RCS_SEC_LSB-8)+:3]
								!= `RCS_SECTOR))
								st_reg <= rcs_pkg::ST_DONE;
						end
					end
					rcs_pkg::ST_RUN:
					begin
						case (cmd_reg)
							`RCS_C_LOW_POWER_CARD_DETECT:
								if (low_power_card_detect_valid)
								begin
									st_reg      <= rcs_pkg::ST_DONE;
									standby_req <= stby_sel_reg;
								end
							`RCS_C_LKEY:
								if (idx_reg < `RCS_KEY_LEN)
								begin
									key_wr   <= 1'b1;
									out_byte <= arg_reg[idx_reg[2:0]];
									idx_reg  <= idx_reg + 4'h1;
								end
								else
									st_reg <= rcs_pkg::ST_DONE;
							`RCS_C_AUTH:
							begin
								if (idx_reg < `RCS_KEY_LEN)
								begin
									auth_wr  <= 1'b1;
									out_byte <= arg_reg[idx_reg[2:0]];
									idx_reg  <= idx_reg + 4'h1;
								end
								else if (!ph_reg)
								begin
									auth_start <= 1'b1;
									ph_reg     <= 1'b1;
								end
								else if (auth_ok || auth_err)
								begin
									st_reg  <= rcs_pkg::ST_DONE;
									q_block <= 1'b0;
								end
							end
							`RCS_C_TAG:
								if (!ph_reg)
								begin
									tag_start <= 1'b1;
									ph_reg    <= 1'b1;
								end
								else if (tag_done)
									st_reg <= rcs_pkg::ST_DONE;
							`RCS_C_RX:
							begin
								rx_on <= !rx_done;
								if (rx_done)
									st_reg <= rcs_pkg::ST_DONE;
							end
							`RCS_C_TX, `RCS_C_TRX:
								if (!ph_reg)
								begin
									tx_start <= 1'b1;
									ph_reg   <= 1'b1;
								end
								else if (tx_done && cmd_reg == `RCS_C_TRX)
									rx_on <= 1'b1;
								else if (tx_done || (rx_on && rx_done))
								begin
									rx_on  <= 1'b0;
									st_reg <= rcs_pkg::ST_DONE;
								end
							`RCS_C_RNG:
								if (!q_push)
								begin
									if (q_full)
										st_reg <= rcs_pkg::ST_DONE;
									else
									begin
										q_push  <= 1'b1;
										q_wdata <= rng_byte;
									end
								end
							`RCS_C_RST:
								soft_reset <= 1'b1;
							`RCS_C_NWR, `RCS_C_NPG, `RCS_C_NRD, `RCS_C_LREG,
							`RCS_C_PROT, `RCS_C_KFET, `RCS_C_KST:
							begin
								// one memory byte per handshake
								if (nvm.req)
								begin
									if (nvm_ack)
									begin
										nvm.req  <= 1'b0;
										nvm.addr <= nvm.addr + 13'h0001;
										cnt_reg  <= cnt_reg - 9'h001;
										idx_reg  <= idx_reg + 4'h1;
										reg_idx  <= reg_idx + 8'h01;
										out_byte <= nvm_rdata;
										q_wdata  <= nvm_rdata;
										q_push   <= cmd_reg == `RCS_C_NRD;
										reg_wr   <= cmd_reg == `RCS_C_LREG
											|| cmd_reg == `RCS_C_PROT;
										key_wr   <= cmd_reg == `RCS_C_KFET;
									end
								end
								else if (cnt_reg == 9'h000)
								begin
									if (cmd_reg == `RCS_C_PROT && !ph_reg)
									begin
										ph_reg   <= 1'b1;
										cnt_reg  <= `RCS_PROT_LEN;
										reg_idx  <= `RCS_TX_REG;
										nvm.addr <= 13'(`RCS_PROT_BASE
											+ 13'(arg_reg[1]) * 13'(`RCS_PROT_LEN));
									end
									else
										st_reg <= rcs_pkg::ST_DONE;
								end
								else if (cmd_reg == `RCS_C_NPG)
								begin
									if (q_level == 8'h00 && !q_pop)
										st_reg <= rcs_pkg::ST_DONE;
									else if (!q_pop)
									begin
										q_pop     <= 1'b1;
										nvm.req   <= 1'b1;
										nvm.we    <= 1'b1;
										nvm.wdata <= q_rdata;
									end
								end
								else
								begin
									nvm.req   <= 1'b1;
									nvm.we    <= cmd_reg == `RCS_C_NWR
										|| cmd_reg == `RCS_C_KST;
									nvm.wdata <= cmd_reg == `RCS_C_KST
										? arg_reg[3'(idx_reg + 4'h1)] : arg_reg[2];
								end
							end
							default:
								st_reg <= rcs_pkg::ST_DONE;
						endcase
					end
					rcs_pkg::ST_DONE:
					begin
						st_reg  <= rcs_pkg::ST_IDLE;
						q_block <= 1'b0;
						rx_on   <= 1'b0;
						nvm.req <= 1'b0;
					end
				endcase
			end
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (rst);

	sequence s_done_idle;
		st_reg == rcs_pkg::ST_DONE ##1 st_reg == rcs_pkg::ST_IDLE;
	endsequence

	idle_code_a: assert property (cmd_wr && w_data_reg[4:0] == `RCS_C_IDLE
		|=> s_done_idle) else $error("idle code did not idle");
	card_hit_a: assert property (ev_set[`RCS_E_CARD]
		|=> ev_reg[`RCS_E_CARD]) else $error("card detect lost");
	standby_sel_a: assert property ($rose(standby_req)
		|-> $past(stby_sel_reg)) else $error("standby without select");
	key_short_a: assert property (st_reg == rcs_pkg::ST_WAIT && !cmd_wr
		&& cmd_reg == `RCS_C_LKEY && q_level < 8'h06
		|=> s_done_idle) else $error("short key not aborted");
	auth_block_a: assert property (in_auth && !$past(cmd_wr) |-> q_block)
		else $error("queue open in auth");
	auth_werr_a: assert property (in_auth && q_host_access
		|=> ev_reg[`RCS_E_WERR]) else $error("write error missed");
	auth_ok_a: assert property (in_auth && auth_ok && !auth_err && !cmd_wr
		|=> ciph_reg ##0 s_done_idle) else $error("auth end wrong");
	auth_err_a: assert property (in_auth && auth_err
		|=> !ciph_reg && ev_reg[`RCS_E_PROT]) else $error("auth error wrong");
	trx_rx_a: assert property (st_reg == rcs_pkg::ST_RUN && cmd_reg == `RCS_C_TRX
		&& ph_reg && !rx_on && tx_done && !cmd_wr
		|=> rx_on) else $error("receiver not on");
	rng_full_a: assert property (q_push && cmd_reg == `RCS_C_RNG
		|-> !$past(q_full)) else $error("push while full");
	args_wait_a: assert property (st_reg == rcs_pkg::ST_WAIT && !cmd_wr
		&& cmd_reg != `RCS_C_LKEY && cmd_reg != `RCS_C_NPG
		&& q_level < 8'(need_args(cmd_reg))
		|=> st_reg == rcs_pkg::ST_WAIT) else $error("started early");
	new_cmd_a: assert property (cmd_wr && w_data_reg[4:0] != `RCS_C_IDLE
		|=> st_reg == rcs_pkg::ST_WAIT) else $error("new code ignored");
	done_evt_a: assert property (st_reg == rcs_pkg::ST_DONE
		|=> ev_reg[`RCS_E_IDLE]) else $error("idle event missing");
endmodule
`default_nettype wire

// ---- rcs_far_model.sv ----
// far-side model: queue, memory, transmitter and tag responder
`timescale 1ns/1ns
`default_nettype none
module rcs_far_model (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic              load,
	input  wire logic [7:0]        load_byte,
	input  wire logic              soft_reset,
	input  wire logic              q_pop,
	input  wire logic              q_push,
	input  wire logic [7:0]        q_wdata,
	output logic [7:0]             q_level,
	output logic [7:0]             q_rdata,
	output logic                   q_full,
	input  wire rcs_pkg::rcs_nvm_t nvm,
	output logic                   nvm_ack,
	output logic [7:0]             nvm_rdata,
	input  wire logic              tx_start,
	output logic                   tx_done,
	input  wire logic              tag_start,
	output logic                   tag_done
);
	logic [7:0] mem [0:7];
	logic [3:0] cnt = 4'h0;
	logic [7:0] pat = 8'h00;
	logic [2:0] txd = 3'h0;
	logic [1:0] wt  = 2'h0;
	logic       slw = 1'b0;
	int         n;
	// empty queue shows a moving pattern, not a stale byte
	assign q_level = {4'h0, cnt};
	assign q_full  = cnt == 4'h8;
	assign q_rdata = cnt != 4'h0 ? mem[0] : pat;
	assign tx_done = txd[2];
	always @(posedge aclk)
	begin
		pat <= pat + 8'h3B;
		txd <= aresetn ? {txd[1:0], tx_start} : 3'h0;
		tag_done <= aresetn && tag_start;
		n = cnt;
		if (q_pop && n > 0)
		begin
			for (int i = 0; i < 7; i++)
				mem[i] = mem[i + 1];
			n--;
		end
		if ((q_push || load) && n < 8)
		begin
			mem[n] = q_push ? q_wdata : load_byte;
			n++;
		end
		// transmitter drains the queue
		if (!aresetn || soft_reset || tx_start)
			n = 0;
		cnt <= 4'(n);
		nvm_ack <= 1'b0;
		nvm_rdata <= pat;
		// memory answers after two or four cycles in turn
		if (nvm.req && !nvm_ack)
		begin
			wt <= wt + 2'h1;
			if (wt == {slw, 1'b1})
			begin
				nvm_ack <= 1'b1;
				nvm_rdata <= nvm.addr[7:0] ^ 8'h5A;
				wt <= 2'h0;
				slw <= ~slw;
			end
		end
	end
endmodule
`default_nettype wire

// ---- rcs_tb_top.sv ----
// self-checking bench of the reader command sequencer
`timescale 1ns/1ns
`default_nettype none
module rcs_tb_top;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready;
	logic bvalid, arready, rvalid, q_full, q_host_access, q_pop, q_push, q_block;
	logic key_wr, auth_wr, auth_start, auth_ok, auth_err, tag_start, tag_done;
	logic tx_start, tx_done, rx_on, rx_done, timer_event, low_power_card_detect_valid, standby_req;
	logic nvm_ack, reg_wr, soft_reset, load, rx_now;
	logic [4:0] awaddr, araddr, pin;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	logic [7:0] q_level, q_rdata, q_wdata, out_byte, low_power_card_detect_i, low_power_card_detect_q, reg_idx;
	logic [7:0] rng_byte, nvm_rdata, load_byte, d;
	logic [20:0] last_nw;
	logic [65:0] note;
	logic [65:0] notes[$];
	logic [7:0] kq[$];
	rcs_pkg::rcs_nvm_t nvm;
	int error_cnt, comparisons, cyc, n_kw, n_aw, n_tx, n_push, n_nw, n_rst;
	assign {low_power_card_detect_valid, rx_done, q_host_access, auth_err, auth_ok} = pin;
	rcs_top u_rcs_top (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
		.wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
		.rready, .q_level, .q_rdata, .q_full, .q_host_access, .q_pop, .q_push, .q_wdata,
		.q_block, .out_byte, .key_wr, .auth_wr, .auth_start, .auth_ok, .auth_err, .tag_start,
		.tag_done, .tx_start, .tx_done, .rx_on, .rx_done, .timer_event, .low_power_card_detect_valid, .low_power_card_detect_i,
		.low_power_card_detect_q, .standby_req, .nvm, .nvm_ack, .nvm_rdata, .reg_wr, .reg_idx, .rng_byte,
		.soft_reset);
	rcs_far_model u_rcs_far_model (.aclk, .aresetn, .load, .load_byte, .soft_reset, .q_pop,
		.q_push, .q_wdata, .q_level, .q_rdata, .q_full, .nvm, .nvm_ack, .nvm_rdata, .tx_start,
		.tx_done, .tag_start, .tag_done);
	initial
	begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end
	always @(posedge aclk)
	begin
		rng_byte <= 8'($urandom);
		cyc <= cyc + 1;
		if (cyc == 5000)
		begin
			error_cnt++;
			close_out();
		end
	end
	// ------
	// monitor: pulse counts and read results
	// ------
	always @(negedge aclk)
	begin
		n_kw += key_wr;
		n_aw += auth_wr;
		n_tx += tx_start;
		n_push += q_push;
		n_rst += soft_reset;
		rx_now = rx_on;
		if (nvm.req && nvm_ack && nvm.we)
		begin
			n_nw++;
			last_nw = {nvm.addr, nvm.wdata};
		end
		if (rvalid && rready)
		begin
			note = notes.pop_front();
			chk({rresp, rdata & note[65:34]}, note[33:0]);
		end
		if (key_wr || auth_wr)
			chk(out_byte, kq.pop_front());
	end
	task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic close_out();
		$display("Counts: %0d mismatches, %0d comparisons", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// ------
	// bus and stimulus tasks
	// ------
	task automatic wr(input logic [4:0] a, input logic [31:0] v, input logic [1:0] r);
		logic ta, tw, done;
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(negedge aclk);
			ta = awvalid & awready;
			tw = wvalid & wready;
			done = bvalid;
			if (done)
				chk(bresp, r);
			@(posedge aclk);
			if (ta)
				awvalid <= 1'b0;
			if (tw)
				wvalid <= 1'b0;
		end while (!done);
		bready <= 1'b0;
		@(posedge aclk);
	endtask
	task automatic rd(input logic [4:0] a, input logic [31:0] v, m, input logic [1:0] r);
		logic ta, done;
		notes.push_back({m, r, v & m});
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(negedge aclk);
			ta = arvalid & arready;
			done = rvalid;
			@(posedge aclk);
			if (ta)
				arvalid <= 1'b0;
		end while (!done);
		rready <= 1'b0;
		@(posedge aclk);
	endtask
	task automatic cmd(input logic [7:0] c);
		wr(5'h00, {24'h0, c}, 2'h0);
		repeat (24) @(posedge aclk);
	endtask
	task automatic ld(input logic [7:0] b);
		load <= 1'b1;
		load_byte <= b;
		@(posedge aclk);
		load <= 1'b0;
		@(posedge aclk);
	endtask
	task automatic ldk(input logic [7:0] b);
		kq.push_back(b);
		ld(b);
	endtask
	task automatic pls(input int k);
		pin <= 5'(1 << k);
		@(posedge aclk);
		pin <= 5'h00;
		repeat (8) @(posedge aclk);
	endtask
	initial
	begin
		{awvalid, wvalid, bready, arvalid, rready, load, pin, low_power_card_detect_i, low_power_card_detect_q} <= '0;
		{awaddr, araddr, wdata, load_byte, timer_event} <= '0;
		wstrb <= 4'hF;
		aresetn <= 1'b0;
		void'($urandom(32'h001F));
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(5'h04, 32'h0, 32'hF, 2'h0);
		rd(5'h0C, 32'hFF00FF00, '1, 2'h0);
		rd(5'h10, 32'h0, '1, 2'h2);
		wr(5'h10, 32'h0, 2'h2);
		repeat (3) ld(8'($urandom));
		cmd(8'h06);
		chk(n_tx, 1);
		rd(5'h08, 32'h21, 32'hFF, 2'h0);
		wr(5'h08, 32'hFF, 2'h0);
		repeat (3) ldk(8'($urandom));
		cmd(8'h02);
		rd(5'h08, 32'h81, 32'hFF, 2'h0);
		repeat (3) ldk(8'($urandom));
		cmd(8'h02);
		chk(n_kw, 6);
		ld(8'h00);
		ld(8'h05);
		cmd(8'h08);
		chk(n_nw, 0);
		d = 8'($urandom);
		ld(d);
		repeat (24) @(posedge aclk);
		chk(last_nw, {13'h0005, d});
		wr(5'h08, 32'hFF, 2'h0);
		ldk(8'h60);
		repeat (5) ldk(8'($urandom));
		cmd(8'h03);
		chk(n_aw, 6);
		rd(5'h04, 32'h05, 32'h7, 2'h0);
		pls(2);
		pls(0);
		rd(5'h04, 32'h02, 32'h7, 2'h0);
		rd(5'h08, 32'h09, 32'hFF, 2'h0);
		ldk(8'h61);
		repeat (5) ldk(8'($urandom));
		cmd(8'h03);
		pls(1);
		rd(5'h04, 32'h0, 32'h2, 2'h0);
		rd(5'h08, 32'h04, 32'h04, 2'h0);
		ldk(8'h60);
		repeat (5) ldk(8'($urandom));
		cmd(8'h03);
		timer_event <= 1'b1;
		@(posedge aclk);
		timer_event <= 1'b0;
		rd(5'h08, 32'h40, 32'h40, 2'h0);
		cmd(8'h00);
		rd(5'h04, 32'h00, 32'h05, 2'h0);
		cmd(8'h05);
		chk(rx_now, 1'b1);
		wr(5'h08, 32'hFF, 2'h0);
		cmd(8'h00);
		chk(rx_now, 1'b0);
		rd(5'h08, 32'h01, 32'h01, 2'h0);
		ld(8'($urandom));
		cmd(8'h07);
		chk({n_tx[7:0], rx_now}, {8'h02, 1'b1});
		pls(3);
		chk(rx_now, 1'b0);
		wr(5'h08, 32'hFF, 2'h0);
		cmd(8'h04);
		rd(5'h08, 32'h01, 32'h01, 2'h0);
		wr(5'h0C, 32'h80208020, 2'h0);
		wr(5'h08, 32'hFF, 2'h0);
		cmd(8'h81);
		low_power_card_detect_i <= 8'h50;
		low_power_card_detect_q <= 8'h81 + 8'($urandom % 127);
		pls(4);
		rd(5'h08, 32'h03, 32'h03, 2'h0);
		rd(5'h04, 32'h08, 32'h08, 2'h0);
		wr(5'h08, 32'hFF, 2'h0);
		cmd(8'h01);
		low_power_card_detect_q <= 8'h40;
		pls(4);
		rd(5'h08, 32'h01, 32'h03, 2'h0);
		rd(5'h04, 32'h00, 32'h08, 2'h0);
		ld(8'h00);
		ld(8'h10);
		ld(8'h02);
		cmd(8'h0A);
		chk(n_push, 2);
		cmd(8'h1C);
		chk(n_push, 8);
		cmd(8'h1F);
		chk(n_rst, 1);
		rd(5'h08, 32'h00, 32'hFF, 2'h0);
		close_out();
	end
endmodule
`default_nettype wire
